// >>> smfpm_top.sv
// field protocol mapper: turns field reads and writes into bus frames
`timescale 1ns/1ps
`default_nettype none

module smfpm_top (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // field request
  input  wire logic        REQ_I,
  input  wire logic        REQ_WRITE_I,
  input  wire logic [2:0]  REQ_TYPE_I,
  input  wire logic [6:0]  REQ_ADDR_I,
  input  wire logic        REQ_CMD_SET_I,
  input  wire logic [7:0]  REQ_CMD_I,
  input  wire logic [3:0]  REQ_BIT_OFS_I,
  input  wire logic [5:0]  REQ_BIT_LEN_I,
  input  wire logic [31:0] REQ_WDATA_I,
  // field answer
  output logic             BUSY_O,
  output logic             DONE_O,
  output logic [31:0]      RDATA_O,
  // block buffers
  input  wire logic        BLK_WR_VALID_I,
  input  wire logic [7:0]  BLK_WR_DATA_I,
  output logic             BLK_WR_READY_O,
  output logic             BLK_RD_VALID_O,
  output logic [7:0]       BLK_RD_DATA_O,
  // bus frame engine
  output logic             BUS_START_O,
  output logic [3:0]       BUS_PROTO_O,
  output logic [7:0]       BUS_ADDR_O,
  output logic [7:0]       BUS_CMD_O,
  output logic [15:0]      BUS_WDATA_O,
  output logic [5:0]       BUS_COUNT_O,
  output logic             BUS_TX_VALID_O,
  output logic [7:0]       BUS_TX_DATA_O,
  input  wire logic        BUS_TX_READY_I,
  input  wire logic        BUS_RX_VALID_I,
  input  wire logic [7:0]  BUS_RX_DATA_I,
  input  wire logic        BUS_DONE_I
);

  typedef enum logic [2:0] {S_IDLE, S_COLLECT, S_ISSUE, S_WAIT, S_NEXT, S_FINISH} smfpm_state_type;

  smfpm_state_type state_r;
  logic [2:0]      type_r;
  logic            wr_r;
  logic [6:0]      addr_r;
  logic [7:0]      base_r;
  logic [3:0]      ofs_r;
  logic [5:0]      len_r;
  logic [31:0]     wdata_r;
  logic [2:0]      idx_r;
  logic [2:0]      last_r;
  logic            phase_wr_r;
  logic [15:0]     reg_r;
  logic [47:0]     acc_r;
  logic [5:0]      pos_r;
  logic [5:0]      rd_cnt_r;
  logic            blk_start_r;
  logic [15:0]     merged;
  logic            blk_cnt_valid;
  logic [5:0]      blk_cnt;
  logic            is_word;
  logic            is_reg;
  logic            eff_wr;

  // bits of the field laid over the registers, lowest register first
  function automatic logic [47:0] place_byte(input logic [47:0] acc, input int bit_at, input logic [7:0] b);
    logic [47:0] res;
    res = acc;
    for (int i = 0; i < 8; i++) begin
      if (bit_at + i < 48) begin
        res[bit_at + i] = b[i];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] extract(input logic [47:0] acc, input logic [3:0] ofs, input logic [5:0] len);
    logic [47:0] sh;
    logic [31:0] mask;
    sh   = acc >> ofs;
    mask = (len >= 6'd32) ? 32'hFFFFFFFF : ((32'h00000001 << len) - 32'h00000001);
    return sh[31:0] & mask;
  endfunction

  assign is_word = (type_r == smfpm_pkg::WORD_ACCESS_TYPE);
  assign is_reg  = (type_r == smfpm_pkg::SEND_RECEIVE_ACCESS_TYPE) ||
                   (type_r == smfpm_pkg::BYTE_ACCESS_TYPE) || is_word;
  // register fields are read first so untouched bits survive the write
  assign eff_wr  = is_reg ? (wr_r & phase_wr_r) : wr_r;

  smfpm_merge u_merge (
    .reg_i    (reg_r),
    .word_i   (is_word),
    .idx_i    (idx_r),
    .ofs_i    (ofs_r),
    .len_i    (len_r),
    .wdata_i  (wdata_r),
    .merged_o (merged)
  );

  smfpm_blk u_blk (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .start_i     (blk_start_r),
    .cnt_valid_o (blk_cnt_valid),
    .cnt_o       (blk_cnt),
    .wr_valid_i  (BLK_WR_VALID_I),
    .wr_data_i   (BLK_WR_DATA_I),
    .wr_ready_o  (BLK_WR_READY_O),
    .tx_valid_o  (BUS_TX_VALID_O),
    .tx_data_o   (BUS_TX_DATA_O),
    .tx_ready_i  (BUS_TX_READY_I)
  );

  // request capture and sequencing
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r     <= S_IDLE;
      type_r      <= smfpm_pkg::QUICK_ACCESS_TYPE;
      wr_r        <= 1'b0;
      addr_r      <= 7'h00;
      base_r      <= smfpm_pkg::CMD_DEFAULT;
      ofs_r       <= 4'h0;
      len_r       <= 6'h00;
      wdata_r     <= 32'h00000000;
      idx_r       <= 3'h0;
      last_r      <= 3'h0;
      phase_wr_r  <= 1'b0;
      blk_start_r <= 1'b0;
      BUSY_O      <= 1'b0;
    end else begin
      blk_start_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (REQ_I) begin
            type_r     <= REQ_TYPE_I;
            wr_r       <= REQ_WRITE_I;
            addr_r     <= REQ_ADDR_I;
            base_r     <= REQ_CMD_SET_I ? REQ_CMD_I : smfpm_pkg::CMD_DEFAULT;
            ofs_r      <= REQ_BIT_OFS_I;
            len_r      <= REQ_BIT_LEN_I;
            wdata_r    <= REQ_WDATA_I;
            idx_r      <= 3'h0;
            phase_wr_r <= 1'b0;
            BUSY_O     <= 1'b1;
            // index of the last register touched by the field, rounded up to whole registers
            if (REQ_TYPE_I == smfpm_pkg::WORD_ACCESS_TYPE) begin
              last_r <= 3'((7'(REQ_BIT_OFS_I) + 7'(REQ_BIT_LEN_I) + 7'd15) / 7'd16 - 7'd1);
            end else begin
              last_r <= 3'((7'(REQ_BIT_OFS_I) + 7'(REQ_BIT_LEN_I) + 7'd7) / 7'd8 - 7'd1);
            end
            if (REQ_TYPE_I == smfpm_pkg::BLOCK_ACCESS_TYPE && REQ_WRITE_I) begin
              blk_start_r <= 1'b1;
              state_r     <= S_COLLECT;
            end else begin
              state_r <= S_ISSUE;
            end
          end
        end
        S_COLLECT: begin
          if (blk_cnt_valid) begin
            state_r <= S_ISSUE;
          end
        end
        S_ISSUE: state_r <= S_WAIT;
        S_WAIT: begin
          if (BUS_DONE_I) begin
            state_r <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (!is_reg) begin
            state_r <= S_FINISH;
          end else if (wr_r && !phase_wr_r) begin
            phase_wr_r <= 1'b1;
            state_r    <= S_ISSUE;
          end else if (idx_r == last_r || type_r == smfpm_pkg::SEND_RECEIVE_ACCESS_TYPE) begin
            state_r <= S_FINISH;
          end else begin
            idx_r      <= idx_r + 3'h1;
            phase_wr_r <= 1'b0;
            state_r    <= S_ISSUE;
          end
        end
        S_FINISH: begin
          BUSY_O  <= 1'b0;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // frame description, latched as the frame is started
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BUS_START_O <= 1'b0;
      BUS_PROTO_O <= smfpm_pkg::PROTO_QUICK;
      BUS_ADDR_O  <= 8'h00;
      BUS_CMD_O   <= 8'h00;
      BUS_WDATA_O <= 16'h0000;
      BUS_COUNT_O <= 6'h00;
    end else if (state_r == S_ISSUE) begin
      BUS_START_O <= 1'b1;
      BUS_ADDR_O  <= {addr_r, eff_wr ? smfpm_pkg::RW_WRITE : smfpm_pkg::RW_READ};
      BUS_CMD_O   <= base_r + (is_word ? smfpm_pkg::WORD_STEP : smfpm_pkg::BYTE_STEP) * 8'(idx_r);
      BUS_WDATA_O <= is_word ? merged : {8'h00, merged[7:0]};
      BUS_COUNT_O <= 6'h00;
      case (type_r)
        smfpm_pkg::QUICK_ACCESS_TYPE: begin
          BUS_PROTO_O <= smfpm_pkg::PROTO_QUICK;
          BUS_ADDR_O  <= {addr_r, wr_r ? smfpm_pkg::RW_QUICK_WRITE : smfpm_pkg::RW_QUICK_READ};
          BUS_CMD_O   <= 8'h00;
          BUS_WDATA_O <= 16'h0000;
        end
        smfpm_pkg::SEND_RECEIVE_ACCESS_TYPE: begin
          BUS_PROTO_O <= eff_wr ? smfpm_pkg::PROTO_SEND : smfpm_pkg::PROTO_RECV;
          BUS_CMD_O   <= eff_wr ? merged[7:0] : 8'h00;
        end
        smfpm_pkg::BYTE_ACCESS_TYPE: BUS_PROTO_O <= eff_wr ? smfpm_pkg::PROTO_WR_BYTE : smfpm_pkg::PROTO_RD_BYTE;
        smfpm_pkg::WORD_ACCESS_TYPE: BUS_PROTO_O <= eff_wr ? smfpm_pkg::PROTO_WR_WORD : smfpm_pkg::PROTO_RD_WORD;
        default: begin
          BUS_PROTO_O <= eff_wr ? smfpm_pkg::PROTO_WR_BLK : smfpm_pkg::PROTO_RD_BLK;
          BUS_COUNT_O <= eff_wr ? blk_cnt : 6'h00;
        end
      endcase
    end else if (BUS_DONE_I) begin
      BUS_START_O <= 1'b0;
    end
  end

  // returned bytes: register images, accumulator and block read stream
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      reg_r          <= 16'h0000;
      acc_r          <= 48'h000000000000;
      pos_r          <= 6'h00;
      rd_cnt_r       <= 6'h00;
      BLK_RD_VALID_O <= 1'b0;
      BLK_RD_DATA_O  <= 8'h00;
    end else begin
      BLK_RD_VALID_O <= 1'b0;
      if (state_r == S_IDLE) begin
        acc_r <= 48'h000000000000;
      end
      if (state_r == S_ISSUE) begin
        pos_r <= 6'h00;
      end else if (state_r == S_WAIT && BUS_RX_VALID_I) begin
        pos_r <= pos_r + 6'h01;
        if (is_reg) begin
          if (pos_r[0]) begin
            reg_r[15:8] <= BUS_RX_DATA_I;
          end else begin
            reg_r[7:0] <= BUS_RX_DATA_I;
          end
          acc_r <= place_byte(acc_r, int'(idx_r) * (is_word ? 16 : 8) + (pos_r[0] ? 8 : 0), BUS_RX_DATA_I);
        end else if (type_r == smfpm_pkg::BLOCK_ACCESS_TYPE) begin
          // count first, then data; bytes past the limit are dropped
          if (pos_r == 6'h00) begin
            rd_cnt_r       <= (BUS_RX_DATA_I > 8'(smfpm_pkg::BLK_MAX)) ? smfpm_pkg::BLK_MAX : BUS_RX_DATA_I[5:0];
            BLK_RD_VALID_O <= 1'b1;
            BLK_RD_DATA_O  <= (BUS_RX_DATA_I > 8'(smfpm_pkg::BLK_MAX)) ? 8'(smfpm_pkg::BLK_MAX) : BUS_RX_DATA_I;
          end else if (pos_r <= rd_cnt_r) begin
            BLK_RD_VALID_O <= 1'b1;
            BLK_RD_DATA_O  <= BUS_RX_DATA_I;
          end
        end
      end
    end
  end

  // completion answer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      DONE_O  <= 1'b0;
      RDATA_O <= 32'h00000000;
    end else begin
      DONE_O <= (state_r == S_FINISH);
      if (state_r == S_FINISH) begin
        RDATA_O <= (is_reg && !wr_r) ? extract(acc_r, ofs_r, len_r) : 32'h00000000;
      end
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_quick_dir;
    $rose(BUS_START_O) && BUS_PROTO_O == smfpm_pkg::PROTO_QUICK |-> BUS_ADDR_O[0] == wr_r;
  endproperty
  a_quick_dir: assert property (p_quick_dir) else $error("quick direction bit wrong");

  property p_quick_nodata;
    BUS_START_O && BUS_PROTO_O == smfpm_pkg::PROTO_QUICK |-> BUS_COUNT_O == 6'h00 && !BUS_TX_VALID_O;
  endproperty
  a_quick_nodata: assert property (p_quick_nodata) else $error("quick frame carries data");

  property p_quick_zero;
    DONE_O && type_r == smfpm_pkg::QUICK_ACCESS_TYPE |-> RDATA_O == 32'h00000000;
  endproperty
  a_quick_zero: assert property (p_quick_zero) else $error("quick read result not zero");

  property p_addr_byte;
    $rose(BUS_START_O) |-> BUS_ADDR_O[7:1] == addr_r;
  endproperty
  a_addr_byte: assert property (p_addr_byte) else $error("address byte malformed");

  property p_cmd_step;
    $rose(BUS_START_O) && (type_r == smfpm_pkg::BYTE_ACCESS_TYPE || is_word) |->
      BUS_CMD_O == 8'(base_r + (is_word ? 8'h02 : 8'h01) * 8'(idx_r));
  endproperty
  a_cmd_step: assert property (p_cmd_step) else $error("command code step wrong");

  property p_send_cmd;
    $rose(BUS_START_O) && BUS_PROTO_O == smfpm_pkg::PROTO_SEND |-> BUS_CMD_O == BUS_WDATA_O[7:0];
  endproperty
  a_send_cmd: assert property (p_send_cmd) else $error("send byte not in command slot");

  property p_blk_limit;
    BUS_START_O |-> BUS_COUNT_O <= 6'h20;
  endproperty
  a_blk_limit: assert property (p_blk_limit) else $error("block count over limit");

  property p_one_frame;
    $rose(BUS_START_O) |=> BUS_START_O until BUS_DONE_I;
  endproperty
  a_one_frame: assert property (p_one_frame) else $error("frame dropped before end");

  property p_done_after;
    DONE_O |-> !BUS_START_O && $past(state_r) == S_FINISH;
  endproperty
  a_done_after: assert property (p_done_after) else $error("done while frame open");

  property p_default_cmd;
    $rose(BUS_START_O) && type_r == smfpm_pkg::BYTE_ACCESS_TYPE && idx_r == 3'h0 |-> BUS_CMD_O == base_r;
  endproperty
  a_default_cmd: assert property (p_default_cmd) else $error("first command code wrong");

  c_quick: cover property (DONE_O && type_r == smfpm_pkg::QUICK_ACCESS_TYPE);
  c_split: cover property (DONE_O && is_reg && last_r != 3'h0);
  c_rmw: cover property (BUS_START_O && BUS_PROTO_O == smfpm_pkg::PROTO_SEND);
  c_blk_wr: cover property (DONE_O && type_r == smfpm_pkg::BLOCK_ACCESS_TYPE && wr_r);

endmodule

`default_nettype wire

// >>> smfpm_pkg.sv
// constants shared by the field protocol mapper and its helpers
package smfpm_pkg;

  // field access types presented by the requester
  localparam logic [2:0] QUICK_ACCESS_TYPE        = 3'h0;
  localparam logic [2:0] SEND_RECEIVE_ACCESS_TYPE = 3'h1;
  localparam logic [2:0] BYTE_ACCESS_TYPE         = 3'h2;
  localparam logic [2:0] WORD_ACCESS_TYPE         = 3'h3;
  localparam logic [2:0] BLOCK_ACCESS_TYPE        = 3'h4;

  // frame kinds handed to the byte-level bus engine
  localparam logic [3:0] PROTO_QUICK   = 4'h0;
  localparam logic [3:0] PROTO_SEND    = 4'h1;
  localparam logic [3:0] PROTO_RECV    = 4'h2;
  localparam logic [3:0] PROTO_WR_BYTE = 4'h3;
  localparam logic [3:0] PROTO_RD_BYTE = 4'h4;
  localparam logic [3:0] PROTO_WR_WORD = 4'h5;
  localparam logic [3:0] PROTO_RD_WORD = 4'h6;
  localparam logic [3:0] PROTO_WR_BLK  = 4'h7;
  localparam logic [3:0] PROTO_RD_BLK  = 4'h8;

  // direction bit in bit 0 of the address byte
  localparam logic RW_QUICK_READ  = 1'b0;
  localparam logic RW_QUICK_WRITE = 1'b1;
  localparam logic RW_WRITE       = 1'b0;
  localparam logic RW_READ        = 1'b1;

  // command codes, register widths and block limit
  localparam logic [7:0] CMD_DEFAULT = 8'h00;
  localparam logic [7:0] BYTE_STEP   = 8'h01;
  localparam logic [7:0] WORD_STEP   = 8'h02;
  localparam int         BYTE_BITS   = 8;
  localparam int         WORD_BITS   = 16;
  localparam logic [5:0] BLK_MAX     = 6'h20;

endpackage

// >>> smfpm_merge.sv
// merges new field bits into one register image, keeping the other bits
`timescale 1ns/1ps
`default_nettype none

module smfpm_merge (
  // register image and its place in the field
  input  wire logic [15:0] reg_i,
  input  wire logic        word_i,
  input  wire logic [2:0]  idx_i,
  // field geometry and new value
  input  wire logic [3:0]  ofs_i,
  input  wire logic [5:0]  len_i,
  input  wire logic [31:0] wdata_i,
  // merged image
  output logic [15:0]      merged_o
);

  // each register bit maps to a global field bit; only bits inside the field change
  always_comb begin
    int g;
    int w;
    g = 0;
    w = word_i ? smfpm_pkg::WORD_BITS : smfpm_pkg::BYTE_BITS;
    merged_o = reg_i;
    for (int b = 0; b < 16; b++) begin
      g = int'(idx_i) * w + b;
      if (b < w && g >= int'(ofs_i) && g < int'(ofs_i) + int'(len_i)) begin
        merged_o[b] = wdata_i[(g - int'(ofs_i)) % 32];
      end
    end
  end

endmodule

`default_nettype wire

// >>> smfpm_blk.sv
// block write path: takes the count byte, then forwards that many bytes up to the block limit
`timescale 1ns/1ps
`default_nettype none

module smfpm_blk (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control from the sequencer
  input  wire logic       start_i,
  output logic            cnt_valid_o,
  output logic [5:0]      cnt_o,
  // requester byte stream
  input  wire logic       wr_valid_i,
  input  wire logic [7:0] wr_data_i,
  output logic            wr_ready_o,
  // bus byte stream
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o,
  input  wire logic       tx_ready_i
);

  logic       armed_r;
  logic [5:0] rem_r;
  logic       take;
  logic       drain;
  logic       armed_nxt;
  logic [5:0] rem_nxt;
  logic       full_nxt;

  assign take  = wr_valid_i & wr_ready_o;
  assign drain = tx_valid_o & tx_ready_i;

  // next state; ready is registered so it must be derived from next values
  always_comb begin
    armed_nxt = armed_r;
    rem_nxt   = rem_r;
    if (start_i) begin
      armed_nxt = 1'b1;
      rem_nxt   = 6'h00;
    end else if (armed_r && take) begin
      armed_nxt = 1'b0;
      // oversized counts are cut to the block limit
      rem_nxt   = (wr_data_i > 8'(smfpm_pkg::BLK_MAX)) ? smfpm_pkg::BLK_MAX : wr_data_i[5:0];
    end else if (take) begin
      rem_nxt = rem_r - 6'h01;
    end
    full_nxt = (take & ~armed_r) | (tx_valid_o & ~drain);
  end

  // one-entry stage: halves throughput but keeps every output a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_r     <= 1'b0;
      rem_r       <= 6'h00;
      cnt_o       <= 6'h00;
      cnt_valid_o <= 1'b0;
      wr_ready_o  <= 1'b0;
      tx_valid_o  <= 1'b0;
      tx_data_o   <= 8'h00;
    end else begin
      armed_r     <= armed_nxt;
      rem_r       <= rem_nxt;
      // one pulse per count byte; a level would still be high when the next block starts
      cnt_valid_o <= armed_r & take & ~start_i;
      if (armed_r && take) begin
        cnt_o <= rem_nxt;
      end
      wr_ready_o <= armed_nxt | ((rem_nxt != 6'h00) & ~full_nxt);
      tx_valid_o <= full_nxt;
      if (take && !armed_r) begin
        tx_data_o <= wr_data_i;
      end
    end
  end

endmodule

`default_nettype wire

// >>> smfpm_bus_model.sv
// behavioural frame engine and target registers on the far side of the mapper
`timescale 1ns/1ps
`default_nettype none

module smfpm_bus_model (
  // clock, reset and pacing
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  // frame request from the mapper
  input  wire logic        start_i,
  input  wire logic [3:0]  proto_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [5:0]  count_i,
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  // frame answer
  output logic             tx_ready_o,
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o,
  output logic             done_o
);
  logic [7:0]  mem [256];
  logic [15:0] wmem [256];
  logic [7:0]  bmem [64];
  logic [7:0]  sr, blen, last_addr, last_cmd;
  logic [3:0]  last_proto;
  logic [5:0]  last_count;
  int          n_frames = 0;
  int          i;

  // one byte per pulse; afterwards the line inverts so no stale value lingers
  task automatic put(input logic [7:0] b);
    rx_valid_o <= 1'b1;
    rx_data_o  <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~b;
    // idle edge so back-to-back bytes never reassign valid in one step
    @(posedge clk_i);
  endtask

  // serves one frame at a time; a quick target has no command registers
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h5A;
    done_o     = 1'b0;
    forever begin
      @(negedge clk_i);
      if (start_i === 1'b1 && rst_i === 1'b0) begin
        n_frames++;
        last_proto = proto_i;
        last_addr  = addr_i;
        last_cmd   = cmd_i;
        last_count = count_i;
        @(posedge clk_i);
        if (slow_i) repeat (5) @(posedge clk_i);
        case (proto_i)
          smfpm_pkg::PROTO_SEND:    sr = cmd_i;
          smfpm_pkg::PROTO_RECV:    put(sr);
          smfpm_pkg::PROTO_WR_BYTE: mem[cmd_i] = wdata_i[7:0];
          smfpm_pkg::PROTO_RD_BYTE: put(mem[cmd_i]);
          smfpm_pkg::PROTO_WR_WORD: wmem[cmd_i] = wdata_i;
          smfpm_pkg::PROTO_RD_WORD: begin
            put(wmem[cmd_i][7:0]);
            put(wmem[cmd_i][15:8]);
          end
          smfpm_pkg::PROTO_WR_BLK: begin
            i = 0;
            // slow mode stalls every third cycle to exercise the stream
            for (int k = 0; k < 400 && i < count_i; k++) begin
              tx_ready_o <= !(slow_i && k % 3 == 0);
              @(negedge clk_i);
              if (tx_valid_i === 1'b1 && tx_ready_o) begin
                bmem[i] = tx_data_i;
                i++;
              end
              @(posedge clk_i);
            end
            tx_ready_o <= 1'b0;
          end
          smfpm_pkg::PROTO_RD_BLK: begin
            put(blen);
            for (i = 0; i < blen; i++) put(bmem[i]);
          end
          default: ;
        endcase
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> smfpm_top_tb.sv
// self-checking bench for the field protocol mapper
`timescale 1ns/1ps
`default_nettype none

module smfpm_top_tb;
  logic        CLK_I = 1'b0, RST_I = 1'b1, REQ_I = 1'b0, REQ_WRITE_I = 1'b0;
  logic        REQ_CMD_SET_I = 1'b0, BLK_WR_VALID_I = 1'b0, slow = 1'b0;
  logic [2:0]  REQ_TYPE_I = 3'h0;
  logic [6:0]  REQ_ADDR_I = 7'h00;
  logic [7:0]  REQ_CMD_I = 8'h00, BLK_WR_DATA_I = 8'h00;
  logic [3:0]  REQ_BIT_OFS_I = 4'h0;
  logic [5:0]  REQ_BIT_LEN_I = 6'h01;
  logic [31:0] REQ_WDATA_I = 32'h0, RDATA_O, rd;
  logic        BUSY_O, DONE_O, BLK_WR_READY_O, BLK_RD_VALID_O, BUS_START_O;
  logic        BUS_TX_VALID_O, BUS_TX_READY_I, BUS_RX_VALID_I, BUS_DONE_I;
  logic [7:0]  BLK_RD_DATA_O, BUS_ADDR_O, BUS_CMD_O, BUS_TX_DATA_O, BUS_RX_DATA_I;
  logic [3:0]  BUS_PROTO_O;
  logic [15:0] BUS_WDATA_O;
  logic [5:0]  BUS_COUNT_O;
  logic [7:0]  rdq [$];
  int          mismatches = 0, n_compared = 0, n_done = 0;

  smfpm_top dut_u (.CLK_I, .RST_I, .REQ_I, .REQ_WRITE_I, .REQ_TYPE_I, .REQ_ADDR_I, .REQ_CMD_SET_I,
    .REQ_CMD_I, .REQ_BIT_OFS_I, .REQ_BIT_LEN_I, .REQ_WDATA_I, .BUSY_O, .DONE_O, .RDATA_O,
    .BLK_WR_VALID_I, .BLK_WR_DATA_I, .BLK_WR_READY_O, .BLK_RD_VALID_O, .BLK_RD_DATA_O,
    .BUS_START_O, .BUS_PROTO_O, .BUS_ADDR_O, .BUS_CMD_O, .BUS_WDATA_O, .BUS_COUNT_O,
    .BUS_TX_VALID_O, .BUS_TX_DATA_O, .BUS_TX_READY_I, .BUS_RX_VALID_I, .BUS_RX_DATA_I, .BUS_DONE_I);

  smfpm_bus_model bfm_u (.clk_i(CLK_I), .rst_i(RST_I), .slow_i(slow), .start_i(BUS_START_O),
    .proto_i(BUS_PROTO_O), .addr_i(BUS_ADDR_O), .cmd_i(BUS_CMD_O), .wdata_i(BUS_WDATA_O),
    .count_i(BUS_COUNT_O), .tx_valid_i(BUS_TX_VALID_O), .tx_data_i(BUS_TX_DATA_O),
    .tx_ready_o(BUS_TX_READY_I), .rx_valid_o(BUS_RX_VALID_I), .rx_data_o(BUS_RX_DATA_I),
    .done_o(BUS_DONE_I));

  // 250 MHz clock
  initial forever #2 CLK_I = ~CLK_I;

  // completion pulses and block read bytes, seen with pre-edge values
  always @(posedge CLK_I) begin
    if (DONE_O === 1'b1) n_done++;
    if (BLK_RD_VALID_O === 1'b1) rdq.push_back(BLK_RD_DATA_O);
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask

  // one field access; dup retries while busy, which must be ignored
  task automatic acc(input logic w, input logic [2:0] t, input logic [6:0] a, input logic cs,
      input logic [7:0] c, input logic [3:0] o, input logic [5:0] l, input logic [31:0] d,
      input logic dup = 1'b0);
    int k;
    @(posedge CLK_I);
    REQ_I <= 1'b1;
    REQ_WRITE_I <= w;
    REQ_TYPE_I <= t;
    REQ_ADDR_I <= a;
    REQ_CMD_SET_I <= cs;
    REQ_CMD_I <= c;
    REQ_BIT_OFS_I <= o;
    REQ_BIT_LEN_I <= l;
    REQ_WDATA_I <= d;
    @(posedge CLK_I);
    REQ_I <= 1'b0;
    if (dup) begin
      @(negedge CLK_I);
      chk("busy while running", 32'h1, BUSY_O);
      @(posedge CLK_I);
      REQ_I <= 1'b1;
      @(posedge CLK_I);
      REQ_I <= 1'b0;
    end
    for (k = 0; k < 2000 && DONE_O !== 1'b1; k++) @(negedge CLK_I);
    if (k == 2000) begin
      mismatches++;
      summarize();
    end
    rd = RDATA_O;
    chk("busy after done", 32'h0, BUSY_O);
  endtask

  // block write stream: count byte, then n bytes from v upward
  task automatic feed(input logic [7:0] n, input logic [7:0] v);
    int k;
    @(posedge CLK_I);
    for (int j = 0; j <= n; j++) begin
      BLK_WR_VALID_I <= 1'b1;
      BLK_WR_DATA_I <= (j == 0) ? n : v + 8'(j - 1);
      // held until the edge at which ready is sampled high
      for (k = 0; k < 2000; k++) begin
        @(posedge CLK_I);
        if (BLK_WR_READY_O === 1'b1) break;
      end
      if (k == 2000) begin
        mismatches++;
        summarize();
      end
    end
    BLK_WR_VALID_I <= 1'b0;
    BLK_WR_DATA_I <= 8'hFF;
  endtask

  task automatic t_quick();
    int n0;
    acc(1'b1, smfpm_pkg::QUICK_ACCESS_TYPE, 7'h61, 1'b0, 8'h00, 4'h0, 6'h01, 32'h1);
    chk("quick write addr", 8'hC3, bfm_u.last_addr);
    chk("quick write kind", smfpm_pkg::PROTO_QUICK, bfm_u.last_proto);
    n0 = bfm_u.n_frames;
    acc(1'b0, smfpm_pkg::QUICK_ACCESS_TYPE, 7'h61, 1'b0, 8'h00, 4'h0, 6'h01, 32'h0, 1'b1);
    chk("quick read addr", 8'hC2, bfm_u.last_addr);
    chk("quick read data", 32'h0, rd);
    repeat (30) @(posedge CLK_I);
    chk("frames while busy", n0 + 1, bfm_u.n_frames);
    chk("done pulses", 2, n_done);
    $display("test quick finished");
  endtask

  task automatic t_sr();
    bfm_u.sr = 8'hF0;
    acc(1'b1, smfpm_pkg::SEND_RECEIVE_ACCESS_TYPE, 7'h62, 1'b0, 8'h00, 4'h2, 6'h05, 32'h7);
    chk("merged byte", 8'h9C, bfm_u.sr);
    chk("send kind", smfpm_pkg::PROTO_SEND, bfm_u.last_proto);
    chk("send command slot", 8'h9C, bfm_u.last_cmd);
    acc(1'b0, smfpm_pkg::SEND_RECEIVE_ACCESS_TYPE, 7'h62, 1'b0, 8'h00, 4'h2, 6'h05, 32'h0);
    chk("receive data", 32'h7, rd);
    chk("receive kind", smfpm_pkg::PROTO_RECV, bfm_u.last_proto);
    $display("test send receive finished");
  endtask

  task automatic t_byte();
    bfm_u.mem[8'h10] = 8'h00;
    bfm_u.mem[8'h11] = 8'hF0;
    acc(1'b1, smfpm_pkg::BYTE_ACCESS_TYPE, 7'h63, 1'b1, 8'h10, 4'h7, 6'h04, 32'hF);
    chk("byte reg 0", 8'h80, bfm_u.mem[8'h10]);
    chk("byte reg 1", 8'hF7, bfm_u.mem[8'h11]);
    chk("byte last cmd", 8'h11, bfm_u.last_cmd);
    chk("byte write kind", smfpm_pkg::PROTO_WR_BYTE, bfm_u.last_proto);
    acc(1'b0, smfpm_pkg::BYTE_ACCESS_TYPE, 7'h63, 1'b1, 8'h10, 4'h7, 6'h04, 32'h0);
    chk("byte split read", 32'hF, rd);
    bfm_u.mem[8'h00] = 8'h5A;
    acc(1'b0, smfpm_pkg::BYTE_ACCESS_TYPE, 7'h63, 1'b0, 8'h33, 4'h0, 6'h08, 32'h0);
    chk("default cmd data", 32'h5A, rd);
    chk("default cmd", 8'h00, bfm_u.last_cmd);
    chk("read addr byte", 8'hC7, bfm_u.last_addr);
    $display("test byte finished");
  endtask

  task automatic t_word();
    bfm_u.wmem[8'h20] = 16'h1234;
    bfm_u.wmem[8'h22] = 16'h5678;
    acc(1'b1, smfpm_pkg::WORD_ACCESS_TYPE, 7'h0B, 1'b1, 8'h20, 4'h8, 6'h10, 32'hABCD);
    chk("word reg 0", 16'hCD34, bfm_u.wmem[8'h20]);
    chk("word reg 1", 16'h56AB, bfm_u.wmem[8'h22]);
    chk("word last cmd", 8'h22, bfm_u.last_cmd);
    chk("word write kind", smfpm_pkg::PROTO_WR_WORD, bfm_u.last_proto);
    acc(1'b0, smfpm_pkg::WORD_ACCESS_TYPE, 7'h0B, 1'b1, 8'h20, 4'h8, 6'h10, 32'h0);
    chk("word read", 32'hABCD, rd);
    $display("test word finished");
  endtask

  task automatic t_blk();
    slow = 1'b1;
    fork
      acc(1'b1, smfpm_pkg::BLOCK_ACCESS_TYPE, 7'h65, 1'b1, 8'h10, 4'h0, 6'h20, 32'h0);
      feed(8'h04, 8'h09);
    join
    slow = 1'b0;
    chk("block count", 6'h04, bfm_u.last_count);
    chk("block cmd", 8'h10, bfm_u.last_cmd);
    chk("block write kind", smfpm_pkg::PROTO_WR_BLK, bfm_u.last_proto);
    for (int j = 0; j < 4; j++) chk("block write byte", 8'(9 + j), bfm_u.bmem[j]);
    for (int j = 0; j < 40; j++) bfm_u.bmem[j] = 8'(j + 1);
    bfm_u.blen = 8'd8;
    rdq.delete();
    acc(1'b0, smfpm_pkg::BLOCK_ACCESS_TYPE, 7'h65, 1'b1, 8'h00, 4'h0, 6'h20, 32'h0);
    chk("block read size", 9, rdq.size());
    for (int j = 0; j < rdq.size(); j++) chk("block read byte", (j == 0) ? 8 : j, rdq[j]);
    bfm_u.blen = 8'd40;
    rdq.delete();
    acc(1'b0, smfpm_pkg::BLOCK_ACCESS_TYPE, 7'h65, 1'b1, 8'h00, 4'h0, 6'h20, 32'h0);
    chk("block clamp size", 33, rdq.size());
    chk("block clamp count", 8'd32, rdq[0]);
    $display("test block finished");
  endtask

  // reset for six cycles, then the scenarios
  initial begin
    repeat (6) @(posedge CLK_I);
    RST_I <= 1'b0;
    t_quick();
    t_sr();
    t_byte();
    t_word();
    t_blk();
    summarize();
  end
endmodule
`default_nettype wire
